// ==== core/mcr_pkg.sv ====
// Purpose: shared constants and carriers for the mode configuration register
// Assumes: 50 MHz core clock, command bus decoded upstream
// Notes:   field positions and timing counts used by the design live here
package mcr_pkg;

  localparam logic [7:0]  MODE_CMD_CODE  = 8'hd1;
  localparam logic [15:0] MODE_RESET_VAL = 16'h0000;
  localparam logic [15:0] MODE_RD_MASK   = 16'h2cff;

  localparam int ALERT_BIT   = 13;
  localparam int RESTART_BIT = 11;
  localparam int LOCK_BIT    = 10;
  localparam int CONV_LO     = 6;
  localparam int AVG_LO      = 4;
  localparam int DEPTH_LO    = 0;

  localparam int CLK_MHZ    = 50;
  localparam int SEQ_WIN_MS = 8;
  localparam int SEQ_WIN_CYC = SEQ_WIN_MS * 1000 * CLK_MHZ;

  localparam int LOCK_CYCLE_MAX = 256;

  // base conversion time in us for code 0, and its cycle count
  localparam int CONV_BASE_US = 1;
  localparam int CONV_BASE_CYC = CONV_BASE_US * CLK_MHZ;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } mcr_cmd_t;

  typedef struct packed {
    logic [1:0] conv_sel;
    logic [1:0] avg_sel;
    logic [3:0] depth_sel;
  } mcr_adc_cfg_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SET1, SEQ_CLR} mcr_seq_state_t;

endpackage

// ==== core/mcr_seq_det.sv ====
// Purpose: detects a set, clear, set pattern on one bit within a window
// Assumes: bit_val is the bit value being written, wr_stb marks each write
// Notes:   a window that runs out drops the partial pattern
module mcr_seq_det #(
  parameter int WIN_CYC = mcr_pkg::SEQ_WIN_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic wr_stb,
  input  wire logic bit_val,
  output logic      hit
);

  // refuse a window shorter than two cycles
  if (WIN_CYC < 2)
  begin : g_bad_win
    $error("window too short");
  end

  localparam int CW = $clog2(WIN_CYC + 1);

  mcr_pkg::mcr_seq_state_t st_r, st_nxt;
  logic [CW-1:0]           cnt_r, cnt_nxt;
  logic                    hit_r, hit_nxt;

  // sequence tracking and window timer
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (st_r != mcr_pkg::SEQ_IDLE)
      cnt_nxt = cnt_r + CW'(1);
    if (st_r != mcr_pkg::SEQ_IDLE && cnt_r >= CW'(WIN_CYC))
    begin
      st_nxt  = mcr_pkg::SEQ_IDLE; // RL13
      cnt_nxt = '0;
    end
    if (wr_stb)
    begin
      unique case (st_r)
        mcr_pkg::SEQ_IDLE:
          if (bit_val)
          begin
            st_nxt  = mcr_pkg::SEQ_SET1;
            cnt_nxt = '0;
          end
        mcr_pkg::SEQ_SET1:
          if (!bit_val && cnt_r < CW'(WIN_CYC))
            st_nxt = mcr_pkg::SEQ_CLR;
        mcr_pkg::SEQ_CLR:
          if (bit_val && cnt_r < CW'(WIN_CYC))
          begin
            hit_nxt = 1'b1; // RL3 RL4
            st_nxt  = mcr_pkg::SEQ_IDLE;
            cnt_nxt = '0;
          end
        default:
          st_nxt = mcr_pkg::SEQ_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r  <= mcr_pkg::SEQ_IDLE;
      cnt_r <= '0;
      hit_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit = hit_r;

endmodule // mcr_seq_det

// ==== core/mcr_mode_reg.sv ====
// Purpose: mode configuration register with restart and lock sequences
// Assumes: command decode upstream presents one-cycle read/write strobes
// Notes:   restart and lock each use their own sequence detector
//
// Contract
// RL1 - bits 15:14, 12 and 9:8 always read back as zero.
// RL2 - alert bit clear: no alert response answer; set: answer.
// RL3 - restart only after set, clear, set on bit 11 within 8ms.
// RL4 - locked state only after set, clear, set on bit 10 within 8ms.
// RL5 - successful password unlock clears bit 10 automatically.
// RL6 - host keeps lock/unlock cycles to 256 per reset.
// RL7 - bits 7:6 select conversion time of 1, 2, 4 or 8 us.
// RL8 - bits 5:4 select no averaging, or 2, 4, 8 samples.
// RL9 - bits 3:0 select 2^code current samples, up to 32768.
// RL10 - host leaves the register alone while supplies run.
// RL11 - unlock password is upper four bytes of serial text field.
// RL12 - lock flag, bit 7 of vendor status, shows protected state live.
// RL13 - unfinished sequence outside window is dropped, restart from next set.
// RL14 - restart and lock sequences use independent timers.
module mcr_mode_reg #(
  parameter int SEQ_WIN_CYC = mcr_pkg::SEQ_WIN_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire mcr_pkg::mcr_cmd_t     cmd_in,
  input  wire logic [31:0]           pw_try,
  input  wire logic                  pw_try_stb,
  input  wire logic [63:0]           serial_text_field,
  input  wire logic                  ara_query,
  output logic [15:0]                rd_data,
  output logic                       rd_valid,
  output logic                       ara_answer,
  output logic                       restart_pulse,
  output logic                       locked,
  output logic [7:0]                 vendor_status_flags,
  output mcr_pkg::mcr_adc_cfg_t      adc_cfg,
  output logic [15:0]                conv_time_cyc,
  output logic [3:0]                 avg_samples,
  output logic [15:0]                current_avg_count,
  output logic [7:0]                 lock_cycle_cnt
);

  logic [15:0] mode_configuration_r, mode_configuration_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic        rd_valid_r, rd_valid_nxt;
  logic        ara_r, ara_nxt;
  logic        locked_r, locked_nxt;
  logic        restart_r;
  logic [15:0] conv_r, conv_nxt;
  logic [3:0]  avg_r, avg_nxt;
  logic [15:0] depth_r, depth_nxt;
  logic [7:0]  lcnt_r, lcnt_nxt;
  logic        wr_hit;
  logic        rd_hit;
  logic        rst_hit;
  logic        lock_hit;
  logic        unlock_ok;

  assign wr_hit = cmd_in.wr_en && cmd_in.cmd == mcr_pkg::MODE_CMD_CODE;
  assign rd_hit = cmd_in.rd_en && cmd_in.cmd == mcr_pkg::MODE_CMD_CODE;
  // password compare on upper serial bytes only
  assign unlock_ok = pw_try_stb && locked_r
                     && pw_try == serial_text_field[63:32]; // RL11

  // independent detectors for restart and lock
  mcr_seq_det #(.WIN_CYC(SEQ_WIN_CYC)) u_restart_det ( // RL14
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .wr_stb   (wr_hit),
    .bit_val  (cmd_in.wdata[mcr_pkg::RESTART_BIT]),
    .hit      (rst_hit)
  );

  mcr_seq_det #(.WIN_CYC(SEQ_WIN_CYC)) u_lock_det ( // RL14
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .wr_stb   (wr_hit),
    .bit_val  (cmd_in.wdata[mcr_pkg::LOCK_BIT]),
    .hit      (lock_hit)
  );

  // register contents, readback and derived settings
  always_comb
  begin
    mode_configuration_nxt = mode_configuration_r;
    if (wr_hit)
      mode_configuration_nxt = cmd_in.wdata & mcr_pkg::MODE_RD_MASK; // RL1
    if (unlock_ok)
      mode_configuration_nxt[mcr_pkg::LOCK_BIT] = 1'b0; // RL5
    rd_valid_nxt = rd_hit;
    rd_data_nxt  = rd_hit ? (mode_configuration_r & mcr_pkg::MODE_RD_MASK)
                          : rd_data_r; // RL1
    ara_nxt = ara_query && mode_configuration_r[mcr_pkg::ALERT_BIT]; // RL2
    locked_nxt = locked_r;
    lcnt_nxt   = lcnt_r;
    if (lock_hit && !locked_r)
    begin
      locked_nxt = 1'b1; // RL4
      if (lcnt_r != 8'hff)
        lcnt_nxt = lcnt_r + 8'h01; // RL6
    end
    if (unlock_ok)
      locked_nxt = 1'b0; // RL5
    conv_nxt = 16'(mcr_pkg::CONV_BASE_CYC)
               << mode_configuration_r[mcr_pkg::CONV_LO +: 2]; // RL7
    unique case (mode_configuration_r[mcr_pkg::AVG_LO +: 2]) // RL8
      2'h0:    avg_nxt = 4'h1;
      2'h1:    avg_nxt = 4'h2;
      2'h2:    avg_nxt = 4'h4;
      default: avg_nxt = 4'h8;
    endcase
    depth_nxt = 16'h0001
                << mode_configuration_r[mcr_pkg::DEPTH_LO +: 4]; // RL9
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_configuration_r <= mcr_pkg::MODE_RESET_VAL;
      rd_data_r            <= 16'h0000;
      rd_valid_r           <= 1'b0;
      ara_r                <= 1'b0;
      locked_r             <= 1'b0;
      restart_r            <= 1'b0;
      conv_r               <= 16'h0000;
      avg_r                <= 4'h0;
      depth_r              <= 16'h0000;
      lcnt_r               <= 8'h00;
    end
    else if (clk_en)
    begin
      mode_configuration_r <= mode_configuration_nxt;
      rd_data_r            <= rd_data_nxt;
      rd_valid_r           <= rd_valid_nxt;
      ara_r                <= ara_nxt;
      locked_r             <= locked_nxt;
      restart_r            <= rst_hit; // RL3
      conv_r               <= conv_nxt;
      avg_r                <= avg_nxt;
      depth_r              <= depth_nxt;
      lcnt_r               <= lcnt_nxt;
    end
  end

  assign rd_data             = rd_data_r;
  assign rd_valid            = rd_valid_r;
  assign ara_answer          = ara_r;
  assign restart_pulse       = restart_r;
  assign locked              = locked_r;
  assign vendor_status_flags = {locked_r, 7'h00}; // RL12
  // adc fields straight from the stored register bits
  assign adc_cfg             = '{
    conv_sel:  mode_configuration_r[mcr_pkg::CONV_LO +: 2],
    avg_sel:   mode_configuration_r[mcr_pkg::AVG_LO +: 2],
    depth_sel: mode_configuration_r[mcr_pkg::DEPTH_LO +: 4]};
  assign conv_time_cyc       = conv_r;
  assign avg_samples         = avg_r;
  assign current_avg_count   = depth_r;
  assign lock_cycle_cnt      = lcnt_r;

endmodule // mcr_mode_reg

// ==== test/mcr_mode_reg_sva.sv ====
// Purpose: port checks for the mode register
// Assumes: clk_en mostly high, low only in a short freeze test
// Notes:   bound to every mcr_mode_reg
module mcr_mode_reg_sva #(
  parameter int SEQ_WIN_CYC = mcr_pkg::SEQ_WIN_CYC
) (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire mcr_pkg::mcr_cmd_t     cmd_in,
  input wire logic [31:0]           pw_try,
  input wire logic                  pw_try_stb,
  input wire logic [63:0]           serial_text_field,
  input wire logic                  ara_query,
  input wire logic [15:0]           rd_data,
  input wire logic                  rd_valid,
  input wire logic                  ara_answer,
  input wire logic                  restart_pulse,
  input wire logic                  locked,
  input wire logic [7:0]            vendor_status_flags,
  input wire mcr_pkg::mcr_adc_cfg_t adc_cfg,
  input wire logic [15:0]           conv_time_cyc,
  input wire logic [3:0]            avg_samples,
  input wire logic [15:0]           current_avg_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a taken read, and a matching unlock try
  sequence s_rd;
    clk_en && cmd_in.rd_en && cmd_in.cmd == 8'hd1;
  endsequence
  sequence s_unl;
    locked && pw_try_stb && pw_try == serial_text_field[63:32];
  endsequence
  // readback and its reserved bits
  AST_RD_ANS: assert property (s_rd |=> rd_valid)
    else $error("read not answered");
  AST_RD_ZERO: assert property (rd_valid |-> !(rd_data & 16'hd300))
    else $error("reserved bit reads one");
  // alert answer, pulses and lock state
  AST_ARA: assert property (ara_answer |-> $past(ara_query))
    else $error("alert answer without query");
  AST_PULSE: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
  AST_UNLOCK: assert property (s_unl |=> !locked)
    else $error("unlock ignored");
  AST_HOLD: assert property (locked &&
    !(pw_try_stb && pw_try == serial_text_field[63:32]) |=> locked)
    else $error("lock lost");
  AST_FLAG: assert property ($rose(locked) |-> ##[0:1]
    vendor_status_flags == 8'h80) else $error("lock flag wrong");
  // derived timing fields follow the register
  AST_CONV: assert property ($past(rst_n) |-> conv_time_cyc ==
    16'd50 << $past(adc_cfg.conv_sel)) else $error("conv time wrong");
  AST_AVG: assert property ($past(rst_n) |-> avg_samples ==
    4'h1 << $past(adc_cfg.avg_sel)) else $error("averaging wrong");
  AST_DEPTH: assert property ($past(rst_n) |-> current_avg_count ==
    16'h1 << $past(adc_cfg.depth_sel)) else $error("depth wrong");
endmodule // mcr_mode_reg_sva

bind mcr_mode_reg mcr_mode_reg_sva #(.SEQ_WIN_CYC(SEQ_WIN_CYC)) u_sva (
  .core_clk, .rst_n, .clk_en, .cmd_in, .pw_try, .pw_try_stb,
  .serial_text_field, .ara_query, .rd_data, .rd_valid, .ara_answer,
  .restart_pulse, .locked, .vendor_status_flags, .adc_cfg,
  .conv_time_cyc, .avg_samples, .current_avg_count);

// ==== test/mcr_host_model.sv ====
// Purpose: command bus host for the mode register
// Assumes: one strobe per access, launched 1 ns after the edge
// Notes:   idle bus lines carry inverted leftovers
module mcr_host_model (
  input  wire logic         core_clk,
  output mcr_pkg::mcr_cmd_t cmd_in,
  input  wire logic [15:0]  rd_data,
  input  wire logic         rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_in = '0;
  // strobe held over one edge, then bus parked
  task automatic acc(input logic w, input logic [15:0] d,
                     output logic [15:0] q, output logic v);
    @(posedge core_clk);
    #1;
    cmd_in = '{wr_en: w, rd_en: !w, cmd: 8'hd1, wdata: d};
    @(posedge core_clk);
    #1;
    cmd_in = '{wr_en: 1'b0, rd_en: 1'b0, cmd: 8'h2e, wdata: ~d};
    q = rd_data;
    v = rd_valid;
  endtask
endmodule // mcr_host_model

// ==== test/mcr_mode_reg_tb_top.sv ====
// Purpose: directed checks of the mode register
// Assumes: sequence window shortened to 20 cycles
// Notes:   clk_en held high except during the final frozen-write check
module mcr_mode_reg_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          WIN = 20;
  localparam logic [63:0] SER = 64'h1234_5678_9abc_def0;
  mcr_pkg::mcr_cmd_t     cmd_in;
  mcr_pkg::mcr_adc_cfg_t adc_cfg;
  logic [31:0]           pw_try;
  logic [15:0]           rd_data, conv_time_cyc, current_avg_count, q;
  logic [7:0]            vendor_status_flags, lock_cycle_cnt;
  logic [3:0]            avg_samples;
  logic                  core_clk, rst_n, pw_try_stb, ara_query, v;
  logic                  rd_valid, ara_answer, restart_pulse, locked;
  logic                  clk_en;
  int                    num_errors, total_checks, pulses;
  mcr_mode_reg #(.SEQ_WIN_CYC(WIN)) u_dut (
    .core_clk, .rst_n, .clk_en, .cmd_in, .pw_try, .pw_try_stb,
    .serial_text_field(SER), .ara_query, .rd_data, .rd_valid,
    .ara_answer, .restart_pulse, .locked, .vendor_status_flags,
    .adc_cfg, .conv_time_cyc, .avg_samples, .current_avg_count,
    .lock_cycle_cnt);
  mcr_host_model u_host (.core_clk, .cmd_in, .rd_data, .rd_valid);
  // clock, pulse tally and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) pulses <= pulses + int'(restart_pulse);
  initial
  begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    report_and_stop;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] d);
    u_host.acc(1'b1, d, q, v);
  endtask
  task automatic rd(input logic [15:0] e);
    u_host.acc(1'b0, 16'h0000, q, v);
    chk("rd_valid", 1, v);
    chk("mode", e, q);
  endtask
  task automatic pw(input logic [31:0] p);
    pw_try = p;
    pw_try_stb = 1'b1;
    cyc(1);
    pw_try_stb = 1'b0;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence of accesses
  initial
  begin
    {rst_n, pw_try_stb, ara_query, pw_try} = '0;
    pulses = 0;
    clk_en = 1'b1;
    cyc(3);
    rst_n = 1'b1;
    rd(16'h0000);
    wr(16'hffff);
    rd(16'h2cff);
    wr(16'h0000);
    cyc(WIN + 5);
    wr(16'h0800);
    wr(16'h0000);
    cyc(WIN + 5);
    wr(16'h0800);
    cyc(3);
    chk("pulses", 0, pulses);
    wr(16'h0000);
    wr(16'h0800);
    cyc(3);
    chk("pulses", 1, pulses);
    cyc(WIN + 5);
    wr(16'h0400);
    wr(16'h0800);
    wr(16'h0c00);
    cyc(3);
    chk("locked", 1, locked);
    chk("pulses", 1, pulses);
    chk("flags", 8'h80, vendor_status_flags);
    chk("locks", 1, lock_cycle_cnt);
    pw(SER[31:0]);
    chk("locked", 1, locked);
    pw(SER[63:32]);
    chk("locked", 0, locked);
    rd(16'h0800);
    ara_query = 1'b1;
    wr(16'h2000);
    cyc(2);
    chk("ara", 1, ara_answer);
    wr(16'h0000);
    cyc(2);
    chk("ara", 0, ara_answer);
    for (int i = 0; i < 4; i++)
    begin
      wr({8'h00, 2'(i), 2'(i), 4'(5 * i)});
      cyc(2);
      chk("conv", 50 << i, conv_time_cyc);
      chk("avg", 1 << i, avg_samples);
      chk("depth", 1 << (5 * i), current_avg_count);
      chk("cfg", {2'(i), 2'(i), 4'(5 * i)}, adc_cfg);
    end
    // frozen clock enable drops the write
    clk_en = 1'b0;
    wr(16'h2000);
    clk_en = 1'b1;
    rd(16'h00ff);
    report_and_stop;
  end
endmodule // mcr_mode_reg_tb_top
